// ===== hdl/can_err_detect.sv
/*
 error detection for one node: crc, ack, form, bit and stuff checks on
 each sampled bit. assumes the bit stream logic marks the segment of every
 sampled bit and the received crc bits arrive in the crc segment.
*/
`timescale 1ns/1ps
`default_nettype none
module can_err_detect (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire can_err_pkg::bit_evt_t i_bit,
   output can_err_pkg::err_kind_t o_err
);
   logic [can_err_pkg::CRC_W-1:0] crc_q, crc_d;
   logic [can_err_pkg::CRC_W-1:0] rx_crc_q, rx_crc_d;
   logic [2:0] run_q, run_d;
   logic last_q, last_d;
   can_err_pkg::err_kind_t err_q, err_d;

   // next crc after one bit
   function automatic logic [can_err_pkg::CRC_W-1:0] crc_step(
      input logic [can_err_pkg::CRC_W-1:0] c, input logic b);
      logic fb;
      fb = b ^ c[can_err_pkg::CRC_W-1];
      crc_step = {c[can_err_pkg::CRC_W-2:0], 1'b0} ^ (fb ? can_err_pkg::CRC_POLY : '0);
   endfunction : crc_step

   // checks evaluated per sample point, result held one cycle
   always_comb begin
      crc_d = crc_q;
      rx_crc_d = rx_crc_q;
      run_d = run_q;
      last_d = last_q;
      err_d = '0;
      if (i_bit.valid) begin
         if (i_bit.frame_start) begin
            crc_d = crc_step('0, i_bit.rx_bit);
            run_d = 3'h1;
            last_d = i_bit.rx_bit;
         end else begin
            // crc covers start of frame through data field, stuff bits excluded
            if (!i_bit.stuff_bit && (i_bit.seg == can_err_pkg::SEG_ARB ||
                i_bit.seg == can_err_pkg::SEG_BODY))
               crc_d = crc_step(crc_q, i_bit.rx_bit);
            if (!i_bit.stuff_bit && i_bit.seg == can_err_pkg::SEG_CRC)
               rx_crc_d = {rx_crc_q[can_err_pkg::CRC_W-2:0], i_bit.rx_bit};
            // stuffing run counted from start of frame up to crc delimiter
            if (i_bit.rx_bit == last_q && run_q != can_err_pkg::STUFF_LIMIT)
               run_d = run_q + 3'h1;
            else if (i_bit.rx_bit != last_q)
               run_d = 3'h1;
            last_d = i_bit.rx_bit;
            if (run_d == can_err_pkg::STUFF_LIMIT && i_bit.seg != can_err_pkg::SEG_IDLE &&
                i_bit.seg != can_err_pkg::SEG_ACK_SLOT && i_bit.seg != can_err_pkg::SEG_TAIL)
               err_d.stuff_err = 1'b1;
         end
         // compare on the crc delimiter, by then all crc bits are in
         if (i_bit.seg == can_err_pkg::SEG_CRC_DELIM && !i_bit.transmitting &&
             rx_crc_q != crc_q)
            err_d.crc_err = 1'b1;
         if ((i_bit.seg == can_err_pkg::SEG_CRC_DELIM || i_bit.seg == can_err_pkg::SEG_TAIL) &&
             !i_bit.rx_bit)
            err_d.form_err = 1'b1;
         if (i_bit.transmitting && i_bit.seg == can_err_pkg::SEG_ACK_SLOT && i_bit.rx_bit)
            err_d.ack_err = 1'b1;
         // dominant over recessive is arbitration loss or ack, not an error
         if (i_bit.transmitting && i_bit.rx_bit != i_bit.tx_bit &&
             !(i_bit.tx_bit && (i_bit.seg == can_err_pkg::SEG_ARB ||
               i_bit.seg == can_err_pkg::SEG_ACK_SLOT)))
            err_d.bit_err = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         crc_q <= '0;
         rx_crc_q <= '0;
         run_q <= 3'h0;
         last_q <= 1'b1;
         err_q <= '0;
      end else begin
         crc_q <= crc_d;
         rx_crc_q <= rx_crc_d;
         run_q <= run_d;
         last_q <= last_d;
         err_q <= err_d;
      end
   end

   assign o_err = err_q;
endmodule : can_err_detect
`default_nettype wire

// ===== hdl/can_err_int.sv
/*
 error counters, fault confinement state, bus-off recovery and the
 interrupt flags of a can controller. assumes sampled-bit events come from
 the bit stream logic on this clock, and software flag writes are one-cycle
 strobes with a clear mask.
*/
// What this block does
// - receiver compares computed crc against received crc, flags crc error on mismatch
// - transmitter flags ack error when ack slot stays recessive, requeues message
// - dominant bit in delimiters, end of frame or interframe space is a form error
// - transmitter flags bit error on mismatch, except recessive-read-dominant in arbitration or ack
// - six equal bits between start of frame and crc delimiter is a stuff error
// - error aborts transmission for retry; error frames dominant if active, recessive if passive
// - in bus-off the node neither transmits nor receives
// - separate receive and transmit counters readable; error-active while both below 128
// - error-passive when either counter is 128 or more
// - bus-off when transmit counter reaches 256, held until recovery seen
// - recovery after 128 runs of 11 recessive bits, back to active unaided
// - warning flag set when either counter at 96 or more, cleared otherwise
// - each source has its own enable; error flag has many sources, cause readable
// - three-bit code reports highest pending source, lowest code wins
// - code considers only enabled sources, advances when the top one clears
// - transmit buffer flag set when buffer empties; software clears by writing zero
// - receive buffer flag set right after end of frame of good reception
// - message error flag set on any error; interrupts only if enabled
// - sleeping with wake enabled, bus activity sets wake flag and ends sleep
// - filtered message with busy receive buffer sets overflow bit, software clears
// - error interrupt on overflow, warning, passive entry and bus-off entry
// - interrupt pending while flag set; software clear blocked while condition lasts
`timescale 1ns/1ps
`default_nettype none
module can_err_int #(
   parameter int N_TX = can_err_pkg::N_TX,
   parameter int N_RX = can_err_pkg::N_RX
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire can_err_pkg::bit_evt_t i_bit,
   input wire logic i_rx_ok, // frame received fine, end of frame passed
   input wire logic i_tx_ok, // frame sent and acknowledged
   input wire logic i_rx_dominant_err, // dominant seen right after own error flag
   input wire logic [N_RX-1:0] i_rx_stored, // message loaded into receive buffer
   input wire logic [N_RX-1:0] i_rx_full_hit, // filtered message, target buffer busy
   input wire logic [N_TX-1:0] i_tx_empty, // transmit buffer emptied
   input wire logic i_sleep,
   input wire logic i_bus_activity, // raw bus pin, asynchronous
   input wire logic i_flag_write, // software writes the flag register
   input wire logic [6:0] i_flag_wdata, // zero bits clear: err, wake, tx0..2, rx0..1
   input wire logic i_msg_err_clear,
   input wire logic i_ovfl_clear,
   input wire logic [6:0] i_int_enable,
   input wire logic i_msg_err_enable,
   output logic [7:0] o_receive_error_counter,
   output logic [8:0] o_transmit_error_counter,
   output can_err_pkg::comm_status_t o_communication_status,
   output can_err_pkg::err_state_t o_err_state,
   output logic [6:0] o_interrupt_flag_register,
   output logic o_message_error_flag,
   output logic [2:0] o_interrupt_code,
   output logic o_irq,
   output logic o_wake,
   output logic o_error_frame_start,
   output logic o_error_frame_level, // 0 = dominant flag, 1 = recessive
   output logic o_retransmit,
   output logic o_bus_enable
);
   localparam int N_SRC = 2 + N_TX + N_RX;

   can_err_pkg::err_kind_t err;
   logic any_err;
   logic [8:0] rec_q, rec_d, tec_q, tec_d;
   can_err_pkg::err_state_t st_q, st_d;
   logic [3:0] idle_run_q, idle_run_d;
   logic [7:0] runs_q, runs_d;
   logic act_m_q, act_s_q, wake_q, wake_d;
   logic [N_SRC-1:0] flags_q, flags_d;
   logic msg_err_q, msg_err_d;
   logic [N_RX-1:0] ovfl_q, ovfl_d;
   logic [4:0] cond_q, cond_d; // rx warn, tx warn, rx passive, tx passive, bus-off
   logic err_event;
   logic [2:0] code;
   logic efs_q, efl_q, retx_q, irq_q, busen_q;
   logic tx_q; // errors arrive a cycle late, so the role is delayed to match
   can_err_pkg::comm_status_t cs_q, cs_d;

   can_err_detect u_detect (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_bit(i_bit),
      .o_err(err)
   );

   assign any_err = |err;

   // saturating add keeps counters from wrapping
   function automatic logic [8:0] sat_add(input logic [8:0] a, input logic [8:0] b);
      logic [9:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[9] ? can_err_pkg::CNT_MAX : s[8:0];
   endfunction : sat_add

   // warning / passive decode used for both counters
   function automatic logic at_least(input logic [8:0] c, input logic [8:0] lim);
      at_least = (c >= lim);
   endfunction : at_least

   // error counters per the can fault confinement steps
   always_comb begin
      rec_d = rec_q;
      tec_d = tec_q;
      if (st_q == can_err_pkg::ST_BUSOFF) begin
         if (st_d == can_err_pkg::ST_ACTIVE) begin
            rec_d = '0;
            tec_d = '0;
         end
      end else if (any_err) begin
         if (tx_q)
            tec_d = sat_add(tec_q, can_err_pkg::TX_ERR_STEP);
         else
            rec_d = sat_add(rec_q, can_err_pkg::RX_ERR_STEP);
      end else if (i_rx_dominant_err) begin
         rec_d = sat_add(rec_q, can_err_pkg::RX_ERR_STEP_BIG);
      end else begin
         if (i_tx_ok && tec_q != '0)
            tec_d = tec_q - can_err_pkg::SUCCESS_STEP;
         // a good frame pulls a passive receiver back below the limit
         if (i_rx_ok && rec_q != '0)
            rec_d = at_least(rec_q, can_err_pkg::PASSIVE_LIMIT) ?
                    can_err_pkg::PASSIVE_LIMIT - 9'h001 : rec_q - can_err_pkg::SUCCESS_STEP;
      end
   end

   // fault confinement state and bus-off recovery counting
   always_comb begin
      st_d = st_q;
      idle_run_d = idle_run_q;
      runs_d = runs_q;
      case (st_q)
         can_err_pkg::ST_ACTIVE, can_err_pkg::ST_PASSIVE: begin
            idle_run_d = '0;
            runs_d = '0;
            if (at_least(tec_q, can_err_pkg::BUSOFF_LIMIT))
               st_d = can_err_pkg::ST_BUSOFF;
            else if (at_least(tec_q, can_err_pkg::PASSIVE_LIMIT) ||
                     at_least(rec_q, can_err_pkg::PASSIVE_LIMIT))
               st_d = can_err_pkg::ST_PASSIVE;
            else
               st_d = can_err_pkg::ST_ACTIVE;
         end
         can_err_pkg::ST_BUSOFF: begin
            if (i_bit.valid) begin
               if (!i_bit.rx_bit)
                  idle_run_d = '0;
               else if (idle_run_q == can_err_pkg::IDLE_RUN_LEN - 4'h1) begin
                  idle_run_d = '0;
                  runs_d = runs_q + 8'h01;
               end else
                  idle_run_d = idle_run_q + 4'h1;
            end
            if (runs_q == can_err_pkg::RECOVERY_RUNS)
               st_d = can_err_pkg::ST_ACTIVE;
         end
         default: st_d = can_err_pkg::ST_ACTIVE;
      endcase
   end

   // error state conditions and the events they produce on entry
   always_comb begin
      cond_d = {at_least(rec_q, can_err_pkg::WARN_LIMIT),
                at_least(tec_q, can_err_pkg::WARN_LIMIT),
                at_least(rec_q, can_err_pkg::PASSIVE_LIMIT),
                at_least(tec_q, can_err_pkg::PASSIVE_LIMIT),
                st_q == can_err_pkg::ST_BUSOFF};
      // rising edges only, so one change gives one flag event
      err_event = |(cond_d & ~cond_q) | |(i_rx_full_hit & ~ovfl_q);
   end

   // sticky flags: hardware set wins over software clear
   always_comb begin
      flags_d = flags_q;
      msg_err_d = msg_err_q;
      ovfl_d = ovfl_q;
      wake_d = 1'b0;
      if (i_flag_write)
         flags_d = flags_q & i_flag_wdata;
      // a flag whose cause still stands cannot be cleared
      if (|cond_d[4:0] || |ovfl_q)
         flags_d[0] = flags_q[0] | flags_d[0];
      for (int t = 0; t < N_TX; t++) begin
         if (i_tx_empty[t])
            flags_d[2+t] = 1'b1;
      end
      for (int r = 0; r < N_RX; r++) begin
         if (i_rx_stored[r] && i_rx_ok)
            flags_d[2+N_TX+r] = 1'b1;
         if (i_ovfl_clear)
            ovfl_d[r] = 1'b0;
         if (i_rx_full_hit[r])
            ovfl_d[r] = 1'b1;
      end
      if (err_event)
         flags_d[0] = 1'b1;
      // wake only from sleep and only when its source is enabled
      if (i_sleep && i_int_enable[1] && act_s_q) begin
         flags_d[1] = 1'b1;
         wake_d = 1'b1;
      end
      if (i_msg_err_clear)
         msg_err_d = 1'b0;
      if (any_err)
         msg_err_d = 1'b1;
   end

   can_int_encode #(
      .N_SRC(N_SRC)
   ) u_encode (
      .i_pending(flags_q),
      .i_enable(i_int_enable),
      .o_code(code)
   );

   // status image for software
   always_comb begin
      cs_d.warn = cond_d[4] | cond_d[3];
      cs_d.rx_warn = cond_d[4];
      cs_d.tx_warn = cond_d[3];
      cs_d.rx_passive = cond_d[2];
      cs_d.tx_passive = cond_d[1];
      cs_d.tx_bus_off = cond_d[0];
      cs_d.rx_ovfl0 = ovfl_q[0];
      cs_d.rx_ovfl1 = ovfl_q[N_RX-1];
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rec_q <= '0;
         tec_q <= '0;
         st_q <= can_err_pkg::ST_ACTIVE;
         idle_run_q <= '0;
         runs_q <= '0;
         flags_q <= '0;
         msg_err_q <= 1'b0;
         ovfl_q <= '0;
         cond_q <= '0;
         cs_q <= '0;
      end else begin
         rec_q <= rec_d;
         tec_q <= tec_d;
         st_q <= st_d;
         idle_run_q <= idle_run_d;
         runs_q <= runs_d;
         flags_q <= flags_d;
         msg_err_q <= msg_err_d;
         ovfl_q <= ovfl_d;
         cond_q <= cond_d;
         cs_q <= cs_d;
      end
   end

   // bus pin synchroniser, active low pin means activity
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         act_m_q <= 1'b0;
         act_s_q <= 1'b0;
      end else begin
         act_m_q <= ~i_bus_activity;
         act_s_q <= act_m_q;
      end
   end

   // registered outputs toward the bit stream logic and the cpu
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         efs_q <= 1'b0;
         efl_q <= 1'b0;
         retx_q <= 1'b0;
         irq_q <= 1'b0;
         busen_q <= 1'b1;
         tx_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         efs_q <= any_err && st_q != can_err_pkg::ST_BUSOFF;
         efl_q <= (st_q == can_err_pkg::ST_PASSIVE);
         retx_q <= any_err && tx_q && st_d != can_err_pkg::ST_BUSOFF;
         irq_q <= (code != can_err_pkg::CODE_NONE) | (msg_err_d & i_msg_err_enable);
         busen_q <= (st_d != can_err_pkg::ST_BUSOFF);
         wake_q <= wake_d;
         tx_q <= i_bit.transmitting;
      end
   end

   assign o_receive_error_counter = rec_q[7:0];
   assign o_transmit_error_counter = tec_q;
   assign o_communication_status = cs_q;
   assign o_err_state = st_q;
   assign o_interrupt_flag_register = flags_q;
   assign o_message_error_flag = msg_err_q;
   assign o_interrupt_code = code;
   assign o_irq = irq_q;
   assign o_wake = wake_q;
   assign o_error_frame_start = efs_q;
   assign o_error_frame_level = efl_q;
   assign o_retransmit = retx_q;
   assign o_bus_enable = busen_q;
endmodule : can_err_int
`default_nettype wire

// ===== hdl/can_int_encode.sv
/*
 priority encoder for the interrupt code: lowest code wins among enabled
 pending sources. assumes pending vector order err, wake, tx0..2, rx0..1.
*/
`timescale 1ns/1ps
`default_nettype none
module can_int_encode #(
   parameter int N_SRC = 7
) (
   input wire logic [N_SRC-1:0] i_pending,
   input wire logic [N_SRC-1:0] i_enable,
   output logic [2:0] o_code
);
   logic [N_SRC-1:0] live;

   // scan from lowest priority upward so the highest one is written last
   always_comb begin
      live = i_pending & i_enable;
      o_code = can_err_pkg::CODE_NONE;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (live[i])
            o_code = 3'(i + 1);
      end
   end
endmodule : can_int_encode
`default_nettype wire

// ===== inc/can_err_pkg.sv
/*
 package for the can error and interrupt logic: limits, counter steps,
 interrupt codes and the structs that carry bit-level events.
 assumes nothing beyond a systemverilog compiler.
*/
package can_err_pkg;
   localparam int CNT_W = 9;
   localparam logic [8:0] PASSIVE_LIMIT = 9'h080; // 128
   localparam logic [8:0] BUSOFF_LIMIT = 9'h100; // 256
   localparam logic [8:0] WARN_LIMIT = 9'h060; // 96
   localparam logic [8:0] CNT_MAX = 9'h1FF;
   localparam logic [8:0] TX_ERR_STEP = 9'h008;
   localparam logic [8:0] RX_ERR_STEP = 9'h001;
   localparam logic [8:0] RX_ERR_STEP_BIG = 9'h008;
   localparam logic [8:0] SUCCESS_STEP = 9'h001;
   localparam logic [3:0] IDLE_RUN_LEN = 4'hB; // 11 recessive bits
   localparam logic [7:0] RECOVERY_RUNS = 8'h80; // 128 runs
   localparam logic [2:0] STUFF_LIMIT = 3'h6; // six equal bits
   localparam int CRC_W = 15;
   localparam logic [14:0] CRC_POLY = 15'h4599;
   localparam int N_TX = 3;
   localparam int N_RX = 2;
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_ERR = 3'h1;
   localparam logic [2:0] CODE_WAKE = 3'h2;
   localparam logic [2:0] CODE_TX0 = 3'h3;
   localparam logic [2:0] CODE_RX0 = 3'h6;

   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_PASSIVE = 2'b01,
      ST_BUSOFF = 2'b10
   } err_state_t;

   // frame position of the current sampled bit, supplied by the bit stream logic
   typedef enum logic [2:0] {
      SEG_IDLE = 3'b000,
      SEG_ARB = 3'b001,
      SEG_BODY = 3'b010, // control and data field
      SEG_CRC = 3'b011,
      SEG_CRC_DELIM = 3'b100,
      SEG_ACK_SLOT = 3'b101,
      SEG_TAIL = 3'b110 // ack delimiter, end of frame, interframe space
   } seg_t;

   typedef struct packed {
      logic valid; // one sample point
      logic rx_bit; // 1 = recessive
      logic tx_bit;
      logic transmitting;
      logic stuff_bit; // destuffed bit, kept out of the crc
      seg_t seg;
      logic frame_start;
   } bit_evt_t;

   typedef struct packed {
      logic crc_err;
      logic ack_err;
      logic form_err;
      logic bit_err;
      logic stuff_err;
   } err_kind_t;

   // communication status bits readable by software
   typedef struct packed {
      logic rx_ovfl1;
      logic rx_ovfl0;
      logic tx_bus_off;
      logic tx_passive;
      logic rx_passive;
      logic tx_warn;
      logic rx_warn;
      logic warn;
   } comm_status_t;
endpackage : can_err_pkg

// ===== testbench/can_bus_node.sv
/*
 model of the other nodes on the bus: a wired-and of our bit and theirs.
 assumes the bench gives our sent bit and whether a far node pulls dominant.
*/
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
   input wire can_err_pkg::bit_evt_t i_evt,
   input wire logic i_pull, // far node drives dominant (acknowledge, overwrite)
   output var can_err_pkg::bit_evt_t o_evt
);
   // dominant wins; an idle bus floats back recessive through the pull-up
   always_comb begin
      o_evt = i_evt;
      o_evt.rx_bit = i_evt.tx_bit & ~i_pull;
   end
endmodule : can_bus_node
`default_nettype wire

// ===== testbench/can_err_int_checker.sv
/*
 assertions on the ports of can_err_int.
 assumes the bind below, one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module can_err_int_checker #(
   parameter int N_TX = 3,
   parameter int N_RX = 2
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire can_err_pkg::bit_evt_t i_bit,
   input wire logic [N_TX-1:0] i_tx_empty,
   input wire logic i_sleep,
   input wire logic i_bus_activity,
   input wire logic [6:0] i_int_enable,
   input wire logic [8:0] o_transmit_error_counter,
   input wire can_err_pkg::comm_status_t o_communication_status,
   input wire can_err_pkg::err_state_t o_err_state,
   input wire logic [6:0] o_interrupt_flag_register,
   input wire logic [2:0] o_interrupt_code,
   input wire logic o_wake,
   input wire logic o_error_frame_start,
   input wire logic o_error_frame_level,
   input wire logic o_bus_enable
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // dominant seen by a transmitter in the tail segments
   sequence tail_dominant;
      i_bit.valid && i_bit.transmitting && i_bit.seg == can_err_pkg::SEG_TAIL && !i_bit.rx_bit
         && o_err_state != can_err_pkg::ST_BUSOFF;
   endsequence
   // bus pulled dominant while asleep with wake enabled, after a quiet cycle
   sequence wake_run;
      !(i_sleep && i_int_enable[1] && !i_bus_activity)
         ##1 (i_sleep && i_int_enable[1] && !i_bus_activity) [*3];
   endsequence
   form_err_frame_a: assert property (tail_dominant |-> ##2 o_error_frame_start)
      else $error("no error frame after tail dominant");
   frame_level_a: assert property (o_error_frame_start |->
      o_error_frame_level == (o_err_state == can_err_pkg::ST_PASSIVE))
      else $error("error frame level does not follow state");
   // bus enable still high marks the cycles before bus-off, recovery is left out
   busoff_entry_a: assert property (o_bus_enable &&
      o_transmit_error_counter >= can_err_pkg::BUSOFF_LIMIT
      |=> o_err_state == can_err_pkg::ST_BUSOFF) else $error("bus-off not entered");
   passive_entry_a: assert property (o_bus_enable &&
      o_transmit_error_counter >= can_err_pkg::PASSIVE_LIMIT
      |=> o_err_state != can_err_pkg::ST_ACTIVE) else $error("still active above passive limit");
   busoff_silent_a: assert property (o_err_state == can_err_pkg::ST_BUSOFF
      |-> !o_bus_enable) else $error("bus enabled in bus-off");
   warn_set_a: assert property (o_transmit_error_counter >= can_err_pkg::WARN_LIMIT
      |=> o_communication_status.tx_warn) else $error("warning missing");
   warn_clear_a: assert property (o_transmit_error_counter < can_err_pkg::WARN_LIMIT
      |=> !o_communication_status.tx_warn) else $error("warning stuck");
   code_none_a: assert property ((o_interrupt_flag_register & i_int_enable) == 7'h00
      |-> o_interrupt_code == can_err_pkg::CODE_NONE) else $error("code without source");
   code_err_a: assert property ((o_interrupt_flag_register[0] && i_int_enable[0])
      |-> o_interrupt_code == can_err_pkg::CODE_ERR) else $error("error code lost");
   tx_flag_a: assert property (i_tx_empty[0] |-> ##[1:2] o_interrupt_flag_register[2])
      else $error("transmit flag not set");
   wake_pulse_a: assert property (wake_run |-> ##[0:2] o_wake)
      else $error("no wake on bus activity");
endmodule : can_err_int_checker
bind can_err_int can_err_int_checker #(.N_TX(N_TX), .N_RX(N_RX)) chk (.i_clk, .i_reset,
   .i_bit, .i_tx_empty, .i_sleep, .i_bus_activity, .i_int_enable, .o_transmit_error_counter,
   .o_communication_status, .o_err_state, .o_interrupt_flag_register, .o_interrupt_code,
   .o_wake, .o_error_frame_start, .o_error_frame_level, .o_bus_enable);
`default_nettype wire

// ===== testbench/tb_top.sv
/*
 bench for can_err_int: error kinds, states, recovery, flags.
 assumes the bus model and a 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_clk = 1'h0;
   logic i_reset = 1'h1;
   can_err_pkg::bit_evt_t ev, bus;
   can_err_pkg::comm_status_t stat;
   can_err_pkg::err_state_t state;
   logic pull, rx_ok, fwr, sleep, bus_act, ovfl_clr, fstart, flevel, bus_en, wake, msg_err, retx, irq;
   logic [1:0] stored, full;
   logic [2:0] tx_empty, code;
   logic [6:0] wdata, int_en, flags;
   logic [7:0] rec;
   logic [8:0] tec, exp_tec;
   int fail_count = 0;
   int n_checks = 0;
   always #2 i_clk = ~i_clk;
   can_bus_node node (.i_evt(ev), .i_pull(pull), .o_evt(bus));
   can_err_int dut (.i_clk(i_clk), .i_reset(i_reset), .i_bit(bus), .i_rx_ok(rx_ok),
      .i_tx_ok(1'h0), .i_rx_dominant_err(1'h0), .i_rx_stored(stored), .i_rx_full_hit(full),
      .i_tx_empty(tx_empty), .i_sleep(sleep), .i_bus_activity(bus_act), .i_flag_write(fwr),
      .i_flag_wdata(wdata), .i_msg_err_clear(1'h0), .i_ovfl_clear(ovfl_clr),
      .i_int_enable(int_en), .i_msg_err_enable(1'h0), .o_receive_error_counter(rec),
      .o_transmit_error_counter(tec), .o_communication_status(stat), .o_err_state(state),
      .o_interrupt_flag_register(flags), .o_message_error_flag(msg_err),
      .o_interrupt_code(code), .o_irq(irq), .o_wake(wake), .o_error_frame_start(fstart),
      .o_error_frame_level(flevel), .o_retransmit(retx), .o_bus_enable(bus_en));
   // inputs move 1 ns after the edge so the design samples settled values
   task automatic step;
      @(posedge i_clk);
      #1;
   endtask : step
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic chkb(input logic got, input logic exp);
      chk({8'h00, got}, {8'h00, exp});
   endtask : chkb
   task automatic send_bit(input can_err_pkg::seg_t s, input logic tx, input logic p,
         input logic tr, input logic sof);
      ev = {1'h1, tx, tx, tr, 1'h0, s, sof};
      pull = p;
      step;
      ev = 9'h0C0; // idle: not valid, recessive
      pull = 1'h0;
   endtask : send_bit
   // one sent bit; frame start and retry pulse stand the cycle after the error, tec +8
   task automatic err_case(input can_err_pkg::seg_t s, input logic p, input logic hit);
      logic lvl;
      lvl = (exp_tec >= 9'h080);
      send_bit(s, 1'h1, p, 1'h1, 1'h0);
      step;
      chkb(fstart, hit);
      chkb(retx, hit);
      if (hit) chkb(flevel, lvl);
      if (hit) exp_tec = exp_tec + 9'h008;
      step;
      chk(tec, exp_tec);
   endtask : err_case
   task automatic flag_clear(input int i);
      wdata = ~(7'h01 << i);
      fwr = 1'h1;
      step;
      fwr = 1'h0;
      step;
   endtask : flag_clear
   task automatic t_kinds;
      err_case(can_err_pkg::SEG_TAIL, 1'h1, 1'h1);
      err_case(can_err_pkg::SEG_ACK_SLOT, 1'h0, 1'h1);
      err_case(can_err_pkg::SEG_BODY, 1'h1, 1'h1);
      err_case(can_err_pkg::SEG_ARB, 1'h1, 1'h0);
      err_case(can_err_pkg::SEG_ACK_SLOT, 1'h1, 1'h0);
      chkb(msg_err, 1'h1);
   endtask : t_kinds
   // climb to error-passive, then to bus-off, then recover on idle runs
   task automatic t_states;
      while (exp_tec < 9'h080) err_case(can_err_pkg::SEG_ACK_SLOT, 1'h0, 1'h1);
      chkb(stat.tx_warn, 1'h1);
      chk(9'(state), 9'(can_err_pkg::ST_PASSIVE));
      flag_clear(0);
      chkb(flags[0], 1'h1);
      chk(9'(code), 9'(can_err_pkg::CODE_ERR));
      chkb(irq, 1'h1);
      while (exp_tec < 9'h100) err_case(can_err_pkg::SEG_ACK_SLOT, 1'h0, 1'h1);
      chk(9'(state), 9'(can_err_pkg::ST_BUSOFF));
      chkb(bus_en, 1'h0);
      repeat (128 * 11 - 1) send_bit(can_err_pkg::SEG_IDLE, 1'h1, 1'h0, 1'h0, 1'h0);
      repeat (4) step;
      chk(9'(state), 9'(can_err_pkg::ST_BUSOFF));
      send_bit(can_err_pkg::SEG_IDLE, 1'h1, 1'h0, 1'h0, 1'h0);
      repeat (4) step;
      exp_tec = 9'h000;
      chk(9'(state), 9'(can_err_pkg::ST_ACTIVE));
      chk(tec, exp_tec);
      chkb(stat.warn, 1'h0);
      flag_clear(0);
      chkb(flags[0], 1'h0);
   endtask : t_states
   // stuffing violation as receiver, then buffer flags and the code walk
   task automatic t_flags;
      send_bit(can_err_pkg::SEG_ARB, 1'h0, 1'h0, 1'h0, 1'h1);
      repeat (5) send_bit(can_err_pkg::SEG_BODY, 1'h0, 1'h0, 1'h0, 1'h0);
      repeat (4) step;
      chk(9'(rec), 9'h001);
      {tx_empty, stored, rx_ok} = 6'h3F;
      step;
      {tx_empty, stored, rx_ok} = 6'h00;
      int_en = 7'h7B;
      repeat (3) step;
      chk(9'(flags), 9'h07C);
      chk(9'(rec), 9'h000);
      chk(9'(code), 9'(can_err_pkg::CODE_TX0 + 3'h1));
      int_en = 7'h7F;
      #1;
      for (int i = 2; i < 7; i++) begin
         chk(9'(code), 9'(can_err_pkg::CODE_TX0 + 3'(i - 2)));
         flag_clear(i);
      end
      chk(9'(code), 9'(can_err_pkg::CODE_NONE));
      full = 2'h1;
      step;
      full = 2'h0;
      repeat (4) step;
      chkb(stat.rx_ovfl0, 1'h1);
      chkb(flags[0], 1'h1);
      ovfl_clr = 1'h1;
      step;
      ovfl_clr = 1'h0;
      flag_clear(0);
      chkb(flags[0], 1'h0);
   endtask : t_flags
   task automatic t_wake;
      int n;
      sleep = 1'h1;
      step;
      bus_act = 1'h0;
      n = 0;
      while (wake !== 1'h1 && n < 8) begin
         step;
         n++;
      end
      chkb(wake, 1'h1);
      step;
      chkb(flags[1], 1'h1);
      {sleep, bus_act} = 2'h1;
   endtask : t_wake
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // main sequence: reset for three cycles, then each scenario in turn
   initial begin
      ev = 9'h0C0;
      {pull, rx_ok, fwr, sleep, ovfl_clr, stored, full, tx_empty} = 12'h000;
      {bus_act, int_en, wdata, exp_tec} = 24'hFFFE00;
      repeat (3) @(posedge i_clk);
      #1;
      i_reset = 1'h0;
      t_kinds;
      t_states;
      t_flags;
      t_wake;
      wrap_up;
   end
   // a hang counts as a mismatch
   initial begin
      #200000;
      fail_count++;
      wrap_up;
   end
endmodule : tb_top
`default_nettype wire
